// file: rtl/csc_top.sv
/*
 * Clock source selection, block gating and HALT/STOP standby control.
 * Assumes a CPU-side register port on clk_sys, interrupt inputs from
 * logic on clk_sys, and an oscillator ready pin from outside.
 */
`timescale 1ns/1ps
`include "csc_defs.svh"

// Summary of operation
// - After reset both oscillators run and the RC clock over eight is selected.
// - PLL clock may reach a pin; the CPU only gets it halved.
// - High-speed oscillator pins connect without any port function setting.
// - A gate bit at one holds its peripheral in reset, clock stopped.
// - Detector disable bit stops the oscillation detector only in HALT.
// - Stop acknowledge never arms while a request is pending and masked.
module csc_top #(
  parameter int NUM_IRQ = 8,               // Interrupt sources
  parameter int NUM_BLK = 5                // Gate registers
) (
  input  wire logic                 clk_sys,           // System clock
  input  wire logic                 arst_n,            // Async reset
  input  wire logic                 clk_en,            // Freezes state low
  input  wire logic [7:0]           reg_addr,          // Register address
  input  wire logic [7:0]           reg_wdata,         // Write data
  input  wire logic                 reg_wr,            // Write strobe
  input  wire logic                 reg_rd,            // Read strobe
  output logic      [7:0]           reg_rdata,         // Read data
  input  wire logic [NUM_IRQ-1:0]   irq_enable,        // Interrupt enables
  input  wire logic [NUM_IRQ-1:0]   irq_request,       // Interrupt requests
  input  wire logic                 master_irq_enable, // Master enable
  input  wire logic                 nmi_request,       // Unmaskable wake
  input  wire logic                 low_osc_ready_pin, // Low osc stable
  input  wire logic                 port2_sec_fn,      // Port 2 clock fn
  output logic                      rc_osc_en,         // RC osc running
  output logic                      low_osc_en,        // Low osc running
  output logic                      hs_osc_en,         // High osc enable
  output logic                      pll_en,            // PLL enable
  output logic      [1:0]           sys_clk_sel,       // CPU clock source
  output logic                      cpu_pll_half,      // CPU takes PLL/2
  output logic                      clk_out_en,        // Clock to pin
  output logic                      osc_pins_connect,  // Osc pins attached
  output logic                      double_low_clock_enable, // LOW_SPEED_SYSTEM_CLOCK x2
  output logic                      cpu_halt,          // In HALT
  output logic                      cpu_stop,          // In STOP
  output logic                      osc_stop_det_en,   // Detector running
  output logic [NUM_BLK*8-1:0]      per_rst_n,         // Peripheral reset
  output logic [NUM_BLK*8-1:0]      per_clk_en         // Peripheral clock
);

  // ****************************************
  // State
  // ****************************************
  logic [7:0]        ctl_reg,   ctl_next;
  logic              dbl_reg,   dbl_next;
  logic              halt_reg,  halt_next;
  logic              stop_reg,  stop_next;
  csc_pkg::csc_ack_e ack_reg,   ack_next;
  logic [7:0]        rdata_reg, rdata_next;
  logic [7:0]        gate_reg  [NUM_BLK];
  logic [7:0]        gate_next [NUM_BLK];
  logic              rdy_meta_reg, rdy_sync_reg;
  logic [NUM_BLK-1:0] gate_hit;
  logic [7:0]        gate_rd;
  logic              pend, wake, ack_block;

  // Address decode per gate register
  genvar g;
  generate
    for (g = 0; g < NUM_BLK; g++) begin : g_dec
      assign gate_hit[g] =
        (reg_addr == `CSC_ADDR_GATE0 + 8'(g * `CSC_GATE_STEP));
    end
  endgenerate

  // Any enabled request; wakes standby regardless of the master enable
  assign pend      = |(irq_enable & irq_request);
  assign wake      = pend | nmi_request;
  assign ack_block = pend & ~master_irq_enable;

  // ****************************************
  // Register file and standby next state
  // ****************************************
  always_comb begin
    ctl_next   = ctl_reg;
    dbl_next   = dbl_reg;
    halt_next  = halt_reg;
    stop_next  = stop_reg;
    ack_next   = ack_reg;
    rdata_next = 8'h00;
    gate_rd    = 8'h00;
    for (int i = 0; i < NUM_BLK; i++) begin
      gate_next[i] = gate_reg[i];
      if (gate_hit[i]) begin
        gate_rd = gate_reg[i];
      end
      if (reg_wr && gate_hit[i]) begin
        gate_next[i] = reg_wdata;
      end
    end
    if (reg_wr) begin
      case (reg_addr)
        // Source writes rely on software ordering
        `CSC_ADDR_CTL:  ctl_next = reg_wdata;
        `CSC_ADDR_CTL1: dbl_next = reg_wdata[`CSC_CTL1_DBL];
        `CSC_ADDR_STBY: begin
          if (reg_wdata[`CSC_STBY_HALT]) begin
            halt_next = 1'b1;
          end
          // Stop is taken only with the code armed
          if (reg_wdata[`CSC_STBY_STOP] &&
              ack_reg == csc_pkg::CSC_ACK_ARMED) begin
            stop_next = 1'b1;
            ack_next  = csc_pkg::CSC_ACK_IDLE;
          end
        end
        `CSC_ADDR_ACK: begin
          if (ack_reg == csc_pkg::CSC_ACK_HALF &&
              reg_wdata == `CSC_ACK_CODE2) begin
            ack_next = csc_pkg::CSC_ACK_ARMED;
          end else if (reg_wdata == `CSC_ACK_CODE1) begin
            ack_next = csc_pkg::CSC_ACK_HALF;
          end else begin
            ack_next = csc_pkg::CSC_ACK_IDLE;
          end
        end
        default: ;
      endcase
    end
    // A pending masked request drops the code, so STOP cannot hang
    if (ack_block) begin
      ack_next = csc_pkg::CSC_ACK_IDLE;
    end
    // Wake wins over entry: no standby with a request already pending
    if (wake) begin
      halt_next = 1'b0;
      stop_next = 1'b0;
    end
    if (reg_rd) begin
      case (reg_addr)
        `CSC_ADDR_CTL:  rdata_next = ctl_reg;
        `CSC_ADDR_CTL1: rdata_next = {7'h00, dbl_reg};
        `CSC_ADDR_STAT: rdata_next = {4'h0, stop_reg, halt_reg,
                                      sys_clk_sel[1], rdy_sync_reg};
        `CSC_ADDR_STBY: rdata_next = {6'h00, stop_reg, halt_reg};
        `CSC_ADDR_ACK:  rdata_next = {6'h00, ack_reg};
        default:        rdata_next = gate_rd;
      endcase
    end
  end

  // Registers; clk_en low freezes everything including the synchroniser
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ctl_reg      <= `CSC_CTL_RESET;
      dbl_reg      <= 1'b0;
      halt_reg     <= 1'b0;
      stop_reg     <= 1'b0;
      ack_reg      <= csc_pkg::CSC_ACK_IDLE;
      rdata_reg    <= 8'h00;
      rdy_meta_reg <= 1'b0;
      rdy_sync_reg <= 1'b0;
      for (int i = 0; i < NUM_BLK; i++) begin
        gate_reg[i] <= `CSC_GATE_RESET;
      end
    end else if (clk_en) begin
      ctl_reg      <= ctl_next;
      dbl_reg      <= dbl_next;
      halt_reg     <= halt_next;
      stop_reg     <= stop_next;
      ack_reg      <= ack_next;
      rdata_reg    <= rdata_next;
      rdy_meta_reg <= low_osc_ready_pin;
      rdy_sync_reg <= rdy_meta_reg;
      for (int i = 0; i < NUM_BLK; i++) begin
        gate_reg[i] <= gate_next[i];
      end
    end
  end

  // ****************************************
  // Clock and standby outputs
  // ****************************************
  // Low oscillator always runs; STOP parks the RC oscillator and the fast ones
  assign rc_osc_en   = ~stop_reg;
  assign low_osc_en  = 1'b1;
  assign hs_osc_en   = ctl_reg[`CSC_CTL_HS_EN] & ~stop_reg;
  assign pll_en      = ctl_reg[`CSC_CTL_PLL_EN] & ~stop_reg;
  assign sys_clk_sel = ctl_reg[`CSC_CTL_SEL_HI:`CSC_CTL_SEL_LO];
  // PLL feeds the CPU only through a halving divider, never at full rate
  assign cpu_pll_half = (sys_clk_sel == csc_pkg::CSC_SRC_PLL);
  // Output pin only drives once port 2 gives up the pin
  assign clk_out_en  = ctl_reg[`CSC_CTL_CLKOUT] & port2_sec_fn
                       & pll_en;
  // Oscillator pins attach straight from the mode, no port setting
  assign osc_pins_connect = hs_osc_en;
  assign double_low_clock_enable = dbl_reg;
  assign cpu_halt    = halt_reg;
  assign cpu_stop    = stop_reg;
  assign osc_stop_det_en =
    ~(halt_reg & gate_reg[`CSC_GATE_DET_REG][`CSC_GATE_DET_BIT]);
  assign reg_rdata   = rdata_reg;

  // Per-peripheral reset and clock stop from the gate bits
  generate
    for (g = 0; g < NUM_BLK * 8; g++) begin : g_gate
      assign per_rst_n[g]  = ~gate_reg[g / 8][g % 8];
      assign per_clk_en[g] = ~gate_reg[g / 8][g % 8];
    end
  endgenerate

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  chk_reset_source: assert property (
    $rose(arst_n) |-> sys_clk_sel == csc_pkg::CSC_SRC_RC8 &&
                      rc_osc_en && low_osc_en)
    else $error("clock source not RC/8 after reset");

  chk_pll_limit: assert property (
    sys_clk_sel == csc_pkg::CSC_SRC_PLL |-> cpu_pll_half)
    else $error("PLL reaches CPU at full rate");

  chk_clkout_port: assert property (
    clk_out_en |-> port2_sec_fn && pll_en)
    else $error("clock driven to pin without port function");

  chk_osc_pins: assert property (
    ctl_reg[`CSC_CTL_HS_EN] && !stop_reg |-> osc_pins_connect)
    else $error("oscillator pins not attached");

  chk_gate_reset: assert property (
    clk_en && reg_wr && reg_addr == `CSC_ADDR_GATE0 && reg_wdata[0]
    |=> !per_rst_n[0] && !per_clk_en[0])
    else $error("gated peripheral not held in reset");

  chk_det_outside: assert property (
    !cpu_halt |-> osc_stop_det_en)
    else $error("detector off outside HALT");

  chk_det_halt: assert property (
    cpu_halt && gate_reg[`CSC_GATE_DET_REG][`CSC_GATE_DET_BIT]
    |-> !osc_stop_det_en)
    else $error("detector left on in HALT");

  chk_ack_block: assert property (
    clk_en && ack_block |=> ack_reg != csc_pkg::CSC_ACK_ARMED)
    else $error("stop code armed with masked request");

  chk_stop_entry: assert property (
    $rose(cpu_stop) |-> $past(ack_reg) == csc_pkg::CSC_ACK_ARMED)
    else $error("STOP entered without armed code");

endmodule : csc_top

// file: shared/csc_defs.svh
/*
 * Register offsets, field positions, reset values and codes of the
 * clock and standby control block.
 * Assumes byte addresses on an 8-bit register port.
 */
`ifndef CSC_DEFS_SVH
`define CSC_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define CSC_ADDR_CTL    8'h00
`define CSC_ADDR_CTL1   8'h04
`define CSC_ADDR_STAT   8'h08
`define CSC_ADDR_STBY   8'h0c
`define CSC_ADDR_ACK    8'h10
`define CSC_ADDR_GATE0  8'h14
`define CSC_GATE_STEP   8'h04

// ****************************************
// Field positions
// ****************************************
`define CSC_CTL_SEL_LO    0
`define CSC_CTL_SEL_HI    1
`define CSC_CTL_PLL_EN    2
`define CSC_CTL_HS_EN     3
`define CSC_CTL_CLKOUT    4
`define CSC_CTL1_DBL      0
`define CSC_STAT_READY    0
`define CSC_STBY_HALT     0
`define CSC_STBY_STOP     1
`define CSC_GATE_DET_REG  4
`define CSC_GATE_DET_BIT  4

// ****************************************
// Reset values and codes
// ****************************************
`define CSC_CTL_RESET   8'h00
`define CSC_GATE_RESET  8'h00
`define CSC_ACK_CODE1   8'h5a
`define CSC_ACK_CODE2   8'ha5

`endif

// file: shared/csc_pkg.sv
/*
 * Types of the clock and standby control block.
 * Assumes csc_defs.svh for all numeric constants.
 */
package csc_pkg;

  // System clock sources; reset value is the RC clock divided by eight
  typedef enum logic [1:0] {
    CSC_SRC_RC8,
    CSC_SRC_LOW_XT,
    CSC_SRC_PLL,
    CSC_SRC_HS_XT
  } csc_src_e;

  // Arming sequence of the stop acknowledge code
  typedef enum logic [1:0] {
    CSC_ACK_IDLE,
    CSC_ACK_HALF,
    CSC_ACK_ARMED
  } csc_ack_e;

endpackage : csc_pkg

// file: bench/csc_top_bench.sv
/*
 * Self-checking bench of the clock and standby control block.
 * Assumes csc_defs.svh on the include path and csc_top compiled first.
 */
`timescale 1ns/1ps
`include "csc_defs.svh"

module csc_top_bench;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic        clk_sys = 1'b0, arst_n = 1'b0, clk_en = 1'b1;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rdat;
  logic        reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  irq_enable = 8'h00, irq_request = 8'h00;
  logic        master_irq_enable = 1'b0, nmi_request = 1'b0;
  logic        low_osc_ready_pin = 1'b0, port2_sec_fn = 1'b0;
  logic        rc_osc_en, low_osc_en, hs_osc_en, pll_en, cpu_pll_half;
  logic        clk_out_en, osc_pins_connect, double_low_clock_enable;
  logic        cpu_halt, cpu_stop, osc_stop_det_en;
  logic [1:0]  sys_clk_sel;
  logic [39:0] per_rst_n, per_clk_en;
  int          errors = 0, comparisons = 0, cycles = 0;

  csc_top csc_top_inst (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_enable(irq_enable),
    .irq_request(irq_request), .master_irq_enable(master_irq_enable),
    .nmi_request(nmi_request), .low_osc_ready_pin(low_osc_ready_pin),
    .port2_sec_fn(port2_sec_fn), .rc_osc_en(rc_osc_en),
    .low_osc_en(low_osc_en), .hs_osc_en(hs_osc_en), .pll_en(pll_en),
    .sys_clk_sel(sys_clk_sel), .cpu_pll_half(cpu_pll_half),
    .clk_out_en(clk_out_en), .osc_pins_connect(osc_pins_connect),
    .double_low_clock_enable(double_low_clock_enable),
    .cpu_halt(cpu_halt), .cpu_stop(cpu_stop),
    .osc_stop_det_en(osc_stop_det_en), .per_rst_n(per_rst_n),
    .per_clk_en(per_clk_en));

  // ****************************************
  // Clock, timeout and shared tasks
  // ****************************************
  // 100 MHz system clock
  always #5 clk_sys = ~clk_sys;

  // Whole run needs under a hundred cycles; a hang is cut at 2000
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [39:0] seen,
                       input logic [39:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One-cycle write; outputs settle just after the returning edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // Interrupt wake held for exactly one sampled edge
  task automatic wake_irq();
    @(posedge clk_sys);
    irq_enable  <= 8'h01;
    irq_request <= 8'h01;
    @(posedge clk_sys);
    irq_enable  <= 8'h00;
    irq_request <= 8'h00;
    #1;
  endtask : wake_irq

  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clk_sys);
    arst_n            <= 1'b1;
    low_osc_ready_pin <= 1'b1;
    #1;
    check("sys_clk_sel", sys_clk_sel, 40'h0);
    check("osc_en", {rc_osc_en, low_osc_en}, 40'h3);
    check("per_rst_n", per_rst_n, {40{1'b1}});
    check("det_en", osc_stop_det_en, 40'h1);
    // Ready pin needs two enabled edges through the synchroniser
    repeat (2) @(posedge clk_sys);
    rd(`CSC_ADDR_STAT, rdat);
    check("ready", rdat[0], 40'h1);
    rd(8'h80, rdat);
    check("unmapped", rdat, 40'h0);
    $display("test reset done");
    // PLL on pin only with port function chosen, CPU gets half
    wr(`CSC_ADDR_CTL, 8'h16);
    check("pll_half", {pll_en, cpu_pll_half, sys_clk_sel}, 40'he);
    check("clk_out_off", clk_out_en, 40'h0);
    @(posedge clk_sys);
    port2_sec_fn <= 1'b1;
    @(posedge clk_sys);
    #1;
    check("clk_out_on", clk_out_en, 40'h1);
    wr(`CSC_ADDR_CTL, 8'h01);
    check("low_sel", {cpu_pll_half, sys_clk_sel}, 40'h1);
    @(posedge clk_sys);
    port2_sec_fn <= 1'b0;
    wr(`CSC_ADDR_CTL, 8'h0b);
    check("hs_pins", {hs_osc_en, osc_pins_connect}, 40'h3);
    wr(`CSC_ADDR_CTL1, 8'h01);
    check("dbl", double_low_clock_enable, 40'h1);
    $display("test clock modes done");
    // Each gate register resets and stops only its own blocks 0 and 7
    for (int g = 0; g < 5; g++) begin
      wr(8'(`CSC_ADDR_GATE0 + g * `CSC_GATE_STEP), 8'h81);
      check("gate_rst", per_rst_n, ~(40'h81 << (8 * g)));
      check("gate_clk", per_clk_en, ~(40'h81 << (8 * g)));
      rd(8'(`CSC_ADDR_GATE0 + g * `CSC_GATE_STEP), rdat);
      check("gate_rd", rdat, 40'h81);
      wr(8'(`CSC_ADDR_GATE0 + g * `CSC_GATE_STEP), 8'h00);
    end
    $display("test gating done");
    // Detector disable only bites while halted
    wr(8'h24, 8'h10);
    check("det_run", osc_stop_det_en, 40'h1);
    wr(`CSC_ADDR_STBY, 8'h01);
    check("halt", {cpu_halt, osc_stop_det_en}, 40'h2);
    wake_irq();
    check("halt_wake", {cpu_halt, osc_stop_det_en}, 40'h1);
    wr(8'h24, 8'h00);
    $display("test halt done");
    // Armed stop stops the fast sources, unmaskable wake ends it
    wr(`CSC_ADDR_ACK, `CSC_ACK_CODE1);
    wr(`CSC_ADDR_ACK, `CSC_ACK_CODE2);
    wr(`CSC_ADDR_STBY, 8'h02);
    check("stop", {cpu_stop, rc_osc_en, hs_osc_en}, 40'h4);
    @(posedge clk_sys);
    nmi_request <= 1'b1;
    @(posedge clk_sys);
    nmi_request <= 1'b0;
    #1;
    check("stop_wake", {cpu_stop, rc_osc_en}, 40'h1);
    // Pending masked request with master enable off refuses arming
    @(posedge clk_sys);
    master_irq_enable <= 1'b1;
    irq_enable        <= 8'h08;
    irq_request       <= 8'h08;
    wr(`CSC_ADDR_ACK, `CSC_ACK_CODE1);
    rd(`CSC_ADDR_ACK, rdat);
    check("ack_mie", rdat, 40'h1);
    @(posedge clk_sys);
    master_irq_enable <= 1'b0;
    wr(`CSC_ADDR_ACK, `CSC_ACK_CODE1);
    rd(`CSC_ADDR_ACK, rdat);
    check("ack_idle", rdat, 40'h0);
    @(posedge clk_sys);
    irq_enable <= 8'h00;
    wr(`CSC_ADDR_ACK, `CSC_ACK_CODE2);
    wr(`CSC_ADDR_STBY, 8'h02);
    check("no_stop", cpu_stop, 40'h0);
    $display("test stop done");
    // Clock enable low must swallow a write and hold every flop
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(`CSC_ADDR_CTL1, 8'h00);
    check("frozen_dbl", double_low_clock_enable, 40'h1);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    // Mid-run reset brings back RC/8 with both slow oscillators
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    #1;
    check("rst_src", {sys_clk_sel, hs_osc_en, pll_en, double_low_clock_enable,
                      rc_osc_en, low_osc_en}, 40'h3);
    $display("test freeze and reset done");
    summarize();
  end
endmodule : csc_top_bench
